// [trace_pkg.sv]
// constants for the debug trace fifo readout block
package trace_pkg;
   localparam int          DEPTH       = 8;
   localparam int          CNT_W       = 4;
   localparam logic [11:0] OFS_HIGH    = 12'h000;
   localparam logic [11:0] OFS_LOW     = 12'h004;
   localparam logic [11:0] OFS_CTRL    = 12'h008;
   localparam logic [11:0] OFS_STATUS  = 12'h00c;
   localparam int          CTRL_ARM    = 0;
   localparam int          CTRL_EVONLY = 1;
   localparam int          CTRL_ENDTR  = 2;
   localparam int          STAT_ARM    = 0;
   localparam int          STAT_CNT    = 8;
   localparam int          SKIP_CYC    = 2;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [3:0]  CNT_RST     = 4'h0;
   typedef enum logic [2:0]
   {
      COF_NONE,
      COF_BRANCH,
      COF_INDIRECT,
      COF_RETURN,
      COF_INTERRUPT
   } cof_kind_e;
endpackage : trace_pkg

// [trace_shift.sv]
// eight-entry shift store for trace words
`timescale 1ns/1ns
module trace_shift
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        push,
   input  wire logic        shift,
   input  wire logic [15:0] din,
   output logic      [15:0] dout,
   output logic      [3:0]  count
);
   logic [15:0] mem [trace_pkg::DEPTH];

   // ----------------------------------------
   // store: push at tail, shift pops head
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < trace_pkg::DEPTH; i++)
            mem[i] <= trace_pkg::WORD_RST;
      end
      else if (push || shift)
      begin
         for (int i = 0; i < trace_pkg::DEPTH - 1; i++)
            mem[i] <= shift ? mem[i+1] : mem[i];
         if (push)
            mem[trace_pkg::DEPTH-1] <= din;
         else if (shift)
            mem[trace_pkg::DEPTH-1] <= trace_pkg::WORD_RST;
         if (push && !shift)
            for (int i = 0; i < trace_pkg::DEPTH - 1; i++)
               mem[i] <= mem[i+1];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= trace_pkg::CNT_RST;
      else if (push && count != 4'(trace_pkg::DEPTH))
         count <= count + 4'h1;
      else if (shift && !push && count != 4'h0)
         count <= count - 4'h1;
   end

   assign dout = mem[0];
endmodule : trace_shift

// [trace_fifo_readout.sv]
// debug trace fifo with apb readout and profiling
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
// What this block does
// R01 - host skips eight minus count
// R02 - normal modes store 16-bit flow addresses
// R03 - host reads high port then low
// R04 - low port read shifts fifo one
// R05 - event-only stores 8-bit data, low read
// R06 - trigger flow and next two dropped
// R07 - end-trace stores flow trigger, keeps storing after it
// R08 - unarmed low read pushes fetched opcode
// R09 - profiling host discards first eight values
// R10 - profile outputs lag by fifo depth
// R11 - taken branch stores opcode, bra/brn nothing
// R12 - indirect jump/call store run-time target
// R13 - interrupts and returns store destination
// R14 - write arms, run end clears arm
// R15 - high port read has no side effect
module trace_fifo_readout
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic      [31:0]         prdata,
   output logic                     pslverr,
   input  wire trace_pkg::cof_kind_e cof_kind,
   input  wire logic                cof_valid,
   input  wire logic                cond_branch,
   input  wire logic [15:0]         cof_addr,
   input  wire logic [15:0]         opcode_addr,
   input  wire logic                trigger,
   input  wire logic                trigger_is_cof,
   input  wire logic                event_valid,
   input  wire logic [7:0]          event_data,
   input  wire logic                run_done
);
   logic        arm;
   logic        evonly;
   logic        endtr;
   logic        capturing;
   logic [1:0]  skip;
   logic        push;
   logic [15:0] push_data;
   logic [15:0] head;
   logic [3:0]  fifo_entry_count;
   logic        acc;
   logic        wr;
   logic        rd_low;
   logic        hit;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign rd_low  = acc && !pwrite && paddr == trace_pkg::OFS_LOW;
   assign hit     = paddr == trace_pkg::OFS_HIGH || paddr == trace_pkg::OFS_LOW
                 || paddr == trace_pkg::OFS_CTRL
                 || paddr == trace_pkg::OFS_STATUS;
   assign pready  = 1'b1;
   assign pslverr = acc && !hit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            trace_pkg::OFS_HIGH:   prdata <= {24'h0, head[15:8]}; // see R15
            trace_pkg::OFS_LOW:    prdata <= {24'h0, head[7:0]};
            trace_pkg::OFS_CTRL:   prdata <= {29'h0, endtr, evonly, arm};
            trace_pkg::OFS_STATUS:
               prdata <= {20'h0, fifo_entry_count, 7'h0, arm};
            default:               prdata <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------
   // control and arm
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         arm    <= 1'b0;
         evonly <= 1'b0;
         endtr  <= 1'b0;
      end
      else if (wr && paddr == trace_pkg::OFS_CTRL)
      begin
         arm    <= pwdata[trace_pkg::CTRL_ARM];  // see R14
         evonly <= pwdata[trace_pkg::CTRL_EVONLY];
         endtr  <= pwdata[trace_pkg::CTRL_ENDTR];
      end
      else if (run_done)
         arm <= 1'b0;                            // see R14
   end

   // begin-trace capture starts at trigger; end-trace captures whenever armed, before and after it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capturing <= 1'b0;
         skip      <= 2'h0;
      end
      else if (!arm)
      begin
         capturing <= 1'b0;
         skip      <= 2'h0;
      end
      else if (endtr)
      begin
         capturing <= 1'b1;
         skip      <= 2'h0;
      end
      else if (trigger && !capturing)
      begin
         capturing <= 1'b1;
         skip      <= 2'(trace_pkg::SKIP_CYC);   // see R06
      end
      else if (skip != 2'h0)
         skip <= skip - 2'h1;
   end

   // ----------------------------------------
   // input selection
   // ----------------------------------------
   function automatic logic cof_keep(input trace_pkg::cof_kind_e k,
                                     input logic cond);
      unique case (k)
         trace_pkg::COF_BRANCH:    cof_keep = cond;  // see R11
         trace_pkg::COF_INDIRECT:  cof_keep = 1'b1;  // see R12
         trace_pkg::COF_RETURN,
         trace_pkg::COF_INTERRUPT: cof_keep = 1'b1;  // see R13
         default:                  cof_keep = 1'b0;
      endcase
   endfunction : cof_keep

   always_comb
   begin
      push      = 1'b0;
      push_data = 16'h0;
      if (!arm)
      begin
         push      = rd_low;                     // see R08
         push_data = opcode_addr;                // see R10
      end
      else if (evonly)
      begin
         push      = capturing && event_valid;
         push_data = {8'h00, event_data};        // see R05
      end
      else if (endtr)
      begin
         push      = cof_valid && cof_keep(cof_kind, cond_branch)
                  && (!trigger || trigger_is_cof); // see R07
         push_data = cof_addr;                   // see R02
      end
      else
      begin
         push      = capturing && skip == 2'h0 && !trigger
                  && cof_valid && cof_keep(cof_kind, cond_branch); // see R06
         push_data = cof_addr;                   // see R02
      end
   end

   trace_shift u_store
   (
      .pclk    (pclk),
      .presetn (presetn),
      .push    (push),
      .shift   (rd_low),                         // see R04
      .din     (push_data),
      .dout    (head),
      .count   (fifo_entry_count)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_low_shift;
      @(posedge pclk) disable iff (!presetn)
      rd_low && !push && fifo_entry_count != 4'h0
         |=> fifo_entry_count == $past(fifo_entry_count) - 4'h1;
   endproperty
   a_low_shift: assert property (p_low_shift)    // see R04
      else $error("low read did not shift");

   property p_high_quiet;
      @(posedge pclk) disable iff (!presetn)
      acc && !pwrite && paddr == trace_pkg::OFS_HIGH && !push
         |=> $stable(head);
   endproperty
   a_high_quiet: assert property (p_high_quiet)  // see R15
      else $error("high read moved fifo");

   property p_profile;
      @(posedge pclk) disable iff (!presetn)
      !arm && rd_low |-> push && push_data == opcode_addr;
   endproperty
   a_profile: assert property (p_profile)        // see R08
      else $error("profile push missing");

   property p_skip;
      @(posedge pclk) disable iff (!presetn)
      arm && !endtr && !evonly && trigger && !capturing
         |-> !push ##1 !push ##1 !push;
   endproperty
   a_skip: assert property (p_skip)              // see R06
      else $error("flow stored too soon");

   property p_done;
      @(posedge pclk) disable iff (!presetn)
      run_done && !(wr && paddr == trace_pkg::OFS_CTRL) |=> !arm;
   endproperty
   a_done: assert property (p_done)              // see R14
      else $error("arm not cleared");

   property p_evonly;
      @(posedge pclk) disable iff (!presetn)
      arm && evonly && push |-> push_data[15:8] == 8'h00;
   endproperty
   a_evonly: assert property (p_evonly)          // see R05
      else $error("event high half used");

   property p_brn;
      @(posedge pclk) disable iff (!presetn)
      arm && !evonly && cof_kind == trace_pkg::COF_BRANCH && !cond_branch
         |-> !push;
   endproperty
   a_brn: assert property (p_brn)                // see R11
      else $error("untaken branch stored");

   property p_cof_data;
      @(posedge pclk) disable iff (!presetn)
      arm && !evonly && push |-> push_data == cof_addr;
   endproperty
   a_cof_data: assert property (p_cof_data)      // see R02
      else $error("flow word wrong");

   property p_count_max;
      @(posedge pclk) disable iff (!presetn)
      fifo_entry_count <= 4'(trace_pkg::DEPTH);
   endproperty
   a_count_max: assert property (p_count_max)    // see R10
      else $error("entry count above depth");

   property p_profile_fill;
      @(posedge pclk) disable iff (!presetn)
      !arm && rd_low && fifo_entry_count != 4'(trace_pkg::DEPTH)
         |=> fifo_entry_count == $past(fifo_entry_count) + 4'h1;
   endproperty
   a_profile_fill: assert property (p_profile_fill) // see R08
      else $error("profile push not counted");

   property p_high_data;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == trace_pkg::OFS_HIGH
         |=> prdata == {24'h0, $past(head[15:8])};
   endproperty
   a_high_data: assert property (p_high_data)    // see R02
      else $error("high port data wrong");

   property p_low_data;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == trace_pkg::OFS_LOW
         |=> prdata == {24'h0, $past(head[7:0])};
   endproperty
   a_low_data: assert property (p_low_data)      // see R04
      else $error("low port data wrong");

   property p_end_trig;
      @(posedge pclk) disable iff (!presetn)
      arm && endtr && !evonly && cof_valid && trigger && trigger_is_cof
         && cof_keep(cof_kind, cond_branch)
         |-> push && push_data == cof_addr;
   endproperty
   a_end_trig: assert property (p_end_trig)      // see R07
      else $error("end trigger flow not stored");

   property p_taken;
      @(posedge pclk) disable iff (!presetn)
      arm && endtr && !evonly && cof_valid && !trigger
         && cof_kind == trace_pkg::COF_BRANCH && cond_branch
         |-> push && push_data == cof_addr;
   endproperty
   a_taken: assert property (p_taken)            // see R11
      else $error("taken branch not stored");

   property p_indirect;
      @(posedge pclk) disable iff (!presetn)
      arm && endtr && !evonly && cof_valid && !trigger
         && cof_kind == trace_pkg::COF_INDIRECT
         |-> push && push_data == cof_addr;
   endproperty
   a_indirect: assert property (p_indirect)      // see R12
      else $error("indirect target not stored");

   property p_return;
      @(posedge pclk) disable iff (!presetn)
      arm && endtr && !evonly && cof_valid && !trigger
         && (cof_kind == trace_pkg::COF_RETURN
         || cof_kind == trace_pkg::COF_INTERRUPT)
         |-> push && push_data == cof_addr;
   endproperty
   a_return: assert property (p_return)          // see R13
      else $error("return target not stored");

   property p_event;
      @(posedge pclk) disable iff (!presetn)
      arm && evonly && capturing && event_valid
         |-> push && push_data[7:0] == event_data;
   endproperty
   a_event: assert property (p_event)            // see R05
      else $error("event value not stored");
endmodule : trace_fifo_readout

// [trace_host.sv]
// host debugger model: apb master reaching the trace fifo ports
`timescale 1ns/1ns
module trace_host
(
   input  wire logic        pclk,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata
);
   initial
   begin
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
   end

   // ----------------------------------------
   // one transfer, held until pready is seen
   // ----------------------------------------
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge pclk);
         psel    <= 1'h1;
         penable <= 1'h0;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'h1;
         do
         begin
            @(posedge pclk);
         end
         while (pready !== 1'h1);
         psel    <= 1'h0;
         penable <= 1'h0;
      end
   endtask : xfer
endmodule : trace_host

// [trace_fifo_readout_bench.sv]
// self-checking bench for the trace fifo readout
`timescale 1ns/1ns
module trace_fifo_readout_bench;
   logic                 pclk, presetn, psel, penable, pwrite, pready;
   logic                 pslverr, cof_valid, cond_branch, trigger;
   logic                 trigger_is_cof, event_valid, run_done;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata;
   logic [15:0]          cof_addr, opcode_addr, w;
   logic [7:0]           event_data;
   trace_pkg::cof_kind_e cof_kind;
   logic [32:0]          exp_q[$];
   logic [15:0]          vals[8];
   int                   error_cnt, checks_done;

   trace_host i_trace_host (.pclk(pclk), .pready(pready), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   trace_fifo_readout i_trace_fifo_readout (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .cof_kind(cof_kind), .cof_valid(cof_valid), .cond_branch(cond_branch),
      .cof_addr(cof_addr), .opcode_addr(opcode_addr), .trigger(trigger),
      .trigger_is_cof(trigger_is_cof), .event_valid(event_valid),
      .event_data(event_data), .run_done(run_done));

   initial
   begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   // ----------------------------------------
   // checking
   // ----------------------------------------
   task check(input logic [32:0] seen, input logic [32:0] want);
      checks_done++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: read %h, want %h", $time, seen, want);
      end
   endtask : check

   // each completed read is compared with the oldest note
   always @(posedge pclk)
   begin
      if ((psel & penable & pready & ~pwrite) === 1'h1 && exp_q.size() > 0)
         check({pslverr, prdata}, exp_q.pop_front());
   end

   task print_verdict;
      if (exp_q.size() != 0)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %0d reads unseen", $time,
                  exp_q.size());
      end
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   // ----------------------------------------
   // stimulus helpers
   // ----------------------------------------
   task rd(input logic [11:0] a, input logic [32:0] want);
      exp_q.push_back(want);
      i_trace_host.xfer(1'h0, a, 32'h0);
   endtask : rd

   task rd_byte(input logic [11:0] a, input logic [7:0] b);
      rd(a, {25'h0, b});
   endtask : rd_byte

   task do_reset;
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
   endtask : do_reset

   task cof(input int k, input logic c, input logic [15:0] a, input logic t);
      @(posedge pclk);
      cof_kind       <= trace_pkg::cof_kind_e'(k);
      cond_branch    <= c;
      cof_addr       <= a;
      cof_valid      <= 1'h1;
      trigger        <= t;
      trigger_is_cof <= t;
      @(posedge pclk);
      cof_valid      <= 1'h0;
      trigger        <= 1'h0;
      trigger_is_cof <= 1'h0;
   endtask : cof

   initial
   begin
      {presetn, cof_valid, cond_branch, trigger, trigger_is_cof} = 5'h0;
      {event_valid, run_done, cof_addr, opcode_addr, event_data} = 42'h0;
      cof_kind = trace_pkg::COF_NONE;
      error_cnt = 0;
      checks_done = 0;
      void'($urandom(6));
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      // unarmed: each low read pushes the fetched opcode address
      for (int i = 0; i < 16; i++)
      begin
         w = (i < 8) ? 16'h0 : vals[i % 8];
         vals[i % 8] = 16'($urandom);
         opcode_addr <= vals[i % 8];
         rd_byte(trace_pkg::OFS_HIGH, w[15:8]);
         rd_byte(trace_pkg::OFS_LOW, w[7:0]);
      end
      // armed end-trace capture of every flow kind
      do_reset;
      i_trace_host.xfer(1'h1, trace_pkg::OFS_CTRL, 32'h5);
      for (int i = 0; i < 8; i++)
      begin
         vals[i] = 16'($urandom);
         cof(i % 4 + 1, 1'h1, vals[i], i == 7);
         if (i == 0)
            cof(1, 1'h0, ~vals[0], 1'h0);
      end
      rd(trace_pkg::OFS_STATUS, 33'h801);
      for (int i = 0; i < 8; i++)
      begin
         rd_byte(trace_pkg::OFS_HIGH, vals[i][15:8]);
         rd_byte(trace_pkg::OFS_HIGH, vals[i][15:8]);
         rd_byte(trace_pkg::OFS_LOW, vals[i][7:0]);
      end
      rd(trace_pkg::OFS_STATUS, 33'h001);
      @(posedge pclk);
      run_done <= 1'h1;
      @(posedge pclk);
      run_done <= 1'h0;
      rd(trace_pkg::OFS_STATUS, 33'h000);
      // event-only capture, unmapped access refused
      do_reset;
      i_trace_host.xfer(1'h1, trace_pkg::OFS_CTRL, 32'h3);
      // begin-trace event capture needs a trigger first
      @(posedge pclk);
      trigger <= 1'h1;
      @(posedge pclk);
      trigger <= 1'h0;
      for (int i = 0; i < 8; i++)
      begin
         vals[i] = 16'($urandom);
         @(posedge pclk);
         event_data  <= vals[i][7:0];
         event_valid <= 1'h1;
         @(posedge pclk);
         event_valid <= 1'h0;
      end
      rd(12'h010, {1'h1, 32'h0});
      i_trace_host.xfer(1'h1, 12'h010, 32'h0);
      rd(trace_pkg::OFS_CTRL, 33'h3);
      for (int i = 0; i < 8; i++)
         rd_byte(trace_pkg::OFS_LOW, vals[i][7:0]);
      // begin-trace: trigger flow and the next two are dropped
      do_reset;
      i_trace_host.xfer(1'h1, trace_pkg::OFS_CTRL, 32'h1);
      @(posedge pclk);
      {cof_valid, trigger, trigger_is_cof, cond_branch} <= 4'hf;
      cof_kind <= trace_pkg::COF_INDIRECT;
      @(posedge pclk);
      {trigger, trigger_is_cof} <= 2'h0;
      repeat (3) @(posedge pclk);
      cof_valid <= 1'h0;
      rd(trace_pkg::OFS_STATUS, 33'h101);
      i_trace_host.xfer(1'h1, trace_pkg::OFS_CTRL, 32'h0);
      rd(trace_pkg::OFS_STATUS, 33'h100);
      repeat (2) @(posedge pclk);
      print_verdict;
   end

   initial
   begin
      #100000;
      error_cnt++;
      print_verdict;
   end
endmodule : trace_fifo_readout_bench
